/* File: src/bac_top.sv */
/*
 * Burst address counter, mask and mirror per port, with an AXI4-Lite
 * slave for readback and a soft clear.
 * Assumes port pins slow against aclk: port clock high and low three aclk
 * each, controls and address steady two aclk around each port clock rise.
 */
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
// Behaviour
// - Master clear acts asynchronously; counters zero, masks ones
// - Master or mask-then-counter clear zeroes counter, mirror
// - Controls sampled on own port clock; chip selects gate only the data float
// - Counter clear zeroes unmasked bits, copies to mirror
// - Counter load from address lines into counter, mirror
// - Counter readback drives address lines after next edge
// - Readback with port enabled floats the data lines
// - Increment unmasked bits by one, two if bit0 masked
// - Increment from all-ones reloads counter from mirror
// - Wrap flag low after an increment to all-ones, high after other increments
// - Clears, loads and master clear raise wrap flag
// - Hold keeps counter, mask and mirror unchanged
// - Mask clear sets every mask bit to one
// - Mask load from the address lines
// - Mask readback drives address lines after next edge
// - Counter and mask change only through their operations
// - Counter, mask and mirror are address wide
`timescale 1ns/1ps
module bac_top
    import bac_pkg::*;
(
    input  wire logic              aclk, // System clock
    input  wire logic              aresetn, // Sync reset, active low
    input  wire logic              master_clear_n, // Async master clear pin
    // AXI4-Lite slave
    input  wire logic [AXI_AW-1:0] s_axi_awaddr, // AW address
    input  wire logic              s_axi_awvalid, // AW valid
    output logic                   s_axi_awready, // AW ready
    input  wire logic [AXI_DW-1:0] s_axi_wdata, // W data
    input  wire logic [3:0]        s_axi_wstrb, // W strobes
    input  wire logic              s_axi_wvalid, // W valid
    output logic                   s_axi_wready, // W ready
    output logic [1:0]             s_axi_bresp, // B response
    output logic                   s_axi_bvalid, // B valid
    input  wire logic              s_axi_bready, // B ready
    input  wire logic [AXI_AW-1:0] s_axi_araddr, // AR address
    input  wire logic              s_axi_arvalid, // AR valid
    output logic                   s_axi_arready, // AR ready
    output logic [AXI_DW-1:0]      s_axi_rdata, // R data
    output logic [1:0]             s_axi_rresp, // R response
    output logic                   s_axi_rvalid, // R valid
    input  wire logic              s_axi_rready, // R ready
    // Memory port pins
    input  wire logic              port_clk       [NUM_PORTS], // Port clock pins
    input  wire bac_pins_t         port_ctl       [NUM_PORTS], // Port control pins
    input  wire logic [ADDR_W-1:0] addr_in        [NUM_PORTS], // Address lines, input
    output logic      [ADDR_W-1:0] addr_out       [NUM_PORTS], // Address lines, readback
    output logic                   addr_oe_n      [NUM_PORTS], // Address drive, low drives
    output logic                   data_float     [NUM_PORTS], // Forces data lines high-Z
    output logic                   count_wrap_flag_n [NUM_PORTS] // Counter wrap flag
);

    // Readable per-port state
    logic [ADDR_W-1:0] count_rd  [NUM_PORTS];
    logic [ADDR_W-1:0] mask_rd   [NUM_PORTS];
    logic [ADDR_W-1:0] mirror_rd [NUM_PORTS];
    wire  [NUM_PORTS-1:0] wrap_rd;

    logic soft_clear_q;

    // Per-port counter, mask and mirror
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            logic [SYNC_W-1:0] raw;
            logic [SYNC_W-1:0] synced;
            logic              clk_prev_q;
            bac_state_t        state_q;
            wire bac_state_t   state_d;
            logic [ADDR_W-1:0] addr_out_q;
            logic [ADDR_W-1:0] addr_out_d;
            logic              oe_n_q;
            logic              oe_n_d;
            logic              float_q;
            logic              float_d;
            bac_op_t           op;

            // Clock, controls and address share one synchroniser so they align
            assign raw = {port_clk[p], port_ctl[p], addr_in[p]};

            bac_sync #(
                .W (SYNC_W)
            ) u_sync (
                .aclk    (aclk),
                .aresetn (aresetn),
                .d       (raw),
                .q       (synced)
            );

            wire              s_clk  = synced[SYNC_W-1];
            wire bac_pins_t   s_pins = synced[SYNC_W-2:ADDR_W];
            wire [ADDR_W-1:0] s_addr = synced[ADDR_W-1:0];
            wire              p_edge = s_clk & ~clk_prev_q;

            bac_decode u_decode (
                .pins (s_pins),
                .op   (op)
            );

            // Operation strobes, one aclk wide per port clock rise
            wire do_cclr  = p_edge && (op == OP_CNT_CLR);
            wire do_cload = p_edge && (op == OP_CNT_LOAD);
            wire do_cread = p_edge && (op == OP_CNT_READ);
            wire do_inc   = p_edge && (op == OP_CNT_INC);
            wire do_mclr  = p_edge && (op == OP_MSK_CLR);
            wire do_mload = p_edge && (op == OP_MSK_LOAD);
            wire do_mread = p_edge && (op == OP_MSK_READ);
            wire do_read  = do_cread | do_mread;

            // Masked bits never move; carries out of the unmasked field drop
            wire [ADDR_W-1:0] masked_keep = state_q.count & ~state_q.mask;
            wire              unmask_full = (state_q.count & state_q.mask) == state_q.mask;
            wire [ADDR_W-1:0] step        = state_q.mask[0] ? STEP_ONE : STEP_TWO;
            wire [ADDR_W-1:0] inc_sum     = ADDR_W'(state_q.count + step);
            wire [ADDR_W-1:0] inc_val     = unmask_full ? state_q.mirror
                                          : (masked_keep | (inc_sum & state_q.mask));
            wire              inc_full    = (inc_val & state_q.mask) == state_q.mask;

            // Next state; anything not listed holds, reserved included
            assign state_d.count  = do_cclr  ? masked_keep
                                  : do_cload ? s_addr
                                  : do_inc   ? inc_val
                                  : state_q.count;
            assign state_d.mirror = do_cclr  ? masked_keep
                                  : do_cload ? s_addr
                                  : state_q.mirror;
            assign state_d.mask   = do_mclr  ? MASK_RST_VAL
                                  : do_mload ? s_addr
                                  : state_q.mask;
            assign state_d.wrap_n = do_inc ? ~inc_full
                                  : (do_cclr | do_cload | do_mclr | do_mload) ? 1'b1
                                  : state_q.wrap_n;

            // Readback is registered at the edge, so it shows after it
            assign addr_out_d = do_cread ? state_q.count
                              : do_mread ? state_q.mask
                              : addr_out_q;
            assign oe_n_d     = p_edge ? ~do_read : oe_n_q;
            assign float_d    = p_edge ? (do_read & ~s_pins.port_select_low
                                                  & s_pins.port_select_high)
                                       : float_q;

            // Master clear is asynchronous; soft clear and aresetn act on aclk
            always_ff @(posedge aclk or negedge master_clear_n) begin
                if (!master_clear_n) begin
                    state_q.count  <= COUNT_RST_VAL;
                    state_q.mask   <= MASK_RST_VAL;
                    state_q.mirror <= MIRROR_RST_VAL;
                    state_q.wrap_n <= 1'b1;
                end else if (!aresetn || soft_clear_q) begin
                    state_q.count  <= COUNT_RST_VAL;
                    state_q.mask   <= MASK_RST_VAL;
                    state_q.mirror <= MIRROR_RST_VAL;
                    state_q.wrap_n <= 1'b1;
                end else begin
                    state_q <= state_d;
                end
            end

            // Pin-facing outputs and the edge detector
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    clk_prev_q <= 1'b0;
                    addr_out_q <= ADDR_OUT_RST;
                    oe_n_q     <= 1'b1;
                    float_q    <= 1'b0;
                end else begin
                    clk_prev_q <= s_clk;
                    addr_out_q <= addr_out_d;
                    oe_n_q     <= oe_n_d;
                    float_q    <= float_d;
                end
            end

            assign addr_out[p]          = addr_out_q;
            assign addr_oe_n[p]         = oe_n_q;
            assign data_float[p]        = float_q;
            assign count_wrap_flag_n[p] = state_q.wrap_n;
            assign count_rd[p]          = state_q.count;
            assign mask_rd[p]           = state_q.mask;
            assign mirror_rd[p]         = state_q.mirror;
            assign wrap_rd[p]           = state_q.wrap_n;
        end
    endgenerate

    // AXI4-Lite write path: address and data taken in either order
    logic              aw_hold_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic              w_hold_q;
    logic [AXI_DW-1:0] wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;

    assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready  = ~w_hold_q & ~bvalid_q;

    wire              aw_take  = s_axi_awvalid & s_axi_awready;
    wire              w_take   = s_axi_wvalid & s_axi_wready;
    wire              aw_have  = aw_hold_q | aw_take;
    wire              w_have   = w_hold_q | w_take;
    wire              wr_fire  = aw_have & w_have & ~bvalid_q;
    wire [AXI_AW-1:0] wr_addr  = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wire [AXI_DW-1:0] wr_data  = w_hold_q ? wdata_q : s_axi_wdata;
    wire [3:0]        wr_strb  = w_hold_q ? wstrb_q : s_axi_wstrb;
    // Only the control register is writable; the rest answer SLVERR
    wire              wr_ctrl  = wr_fire && (wr_addr == REG_CTRL);
    wire              clear_go = wr_ctrl & wr_strb[0] & wr_data[CTRL_SOFT_CLEAR_BIT];

    // Write channel state; soft clear is a one-cycle pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q    <= 1'b0;
            awaddr_q     <= '0;
            w_hold_q     <= 1'b0;
            wdata_q      <= '0;
            wstrb_q      <= '0;
            bvalid_q     <= 1'b0;
            bresp_q      <= RESP_OKAY;
            soft_clear_q <= 1'b0;
        end else begin
            aw_hold_q    <= aw_have & ~wr_fire;
            w_hold_q     <= w_have & ~wr_fire;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            soft_clear_q <= clear_go;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // AXI4-Lite read path: one read outstanding, answer next cycle
    logic              rvalid_q;
    logic [AXI_DW-1:0] rdata_q;
    logic [1:0]        rresp_q;
    logic [AXI_DW-1:0] port_word [NUM_PORTS];
    wire  [NUM_PORTS-1:0] port_hit;
    logic [AXI_DW-1:0] port_or;

    assign s_axi_arready = ~rvalid_q;
    wire ar_take = s_axi_arvalid & s_axi_arready;

    // Per-port read decode
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_rd
            localparam logic [AXI_AW-1:0] PB = AXI_AW'(REG_PORT_BASE + p * REG_PORT_STRIDE);
            wire hit_c = s_axi_araddr == AXI_AW'(PB + REG_COUNT_OFS);
            wire hit_m = s_axi_araddr == AXI_AW'(PB + REG_MASK_OFS);
            wire hit_r = s_axi_araddr == AXI_AW'(PB + REG_MIRROR_OFS);
            assign port_hit[p]  = hit_c | hit_m | hit_r;
            assign port_word[p] = hit_c ? AXI_DW'(count_rd[p])
                                : hit_m ? AXI_DW'(mask_rd[p])
                                : hit_r ? AXI_DW'(mirror_rd[p])
                                : '0;
        end
    endgenerate

    // At most one port word is non-zero, so an OR merges them
    always_comb begin
        port_or = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            port_or = port_or | port_word[i];
        end
    end

    wire hit_ctrl  = s_axi_araddr == REG_CTRL;
    wire hit_flags = s_axi_araddr == REG_FLAGS;
    wire rd_hit    = hit_ctrl | hit_flags | (|port_hit);
    wire [AXI_DW-1:0] rd_word = hit_flags ? AXI_DW'(wrap_rd) : port_or;

    // Read data is captured when the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule

/* File: src/bac_pkg.sv */
/*
 * Shared constants and types of the burst address counter block.
 * Assumes one aclk domain and an AXI4-Lite register bus.
 */
package bac_pkg;

    // Two ports, each with its own counter, mask and mirror
    localparam int NUM_PORTS = 2;
    // Port address width of the larger variant
    localparam int ADDR_W    = 18;
    localparam int AXI_AW    = 8;
    localparam int AXI_DW    = 32;

    // Register reset values
    localparam logic [ADDR_W-1:0] COUNT_RST_VAL  = 18'h00000;
    localparam logic [ADDR_W-1:0] MASK_RST_VAL   = 18'h3ffff;
    localparam logic [ADDR_W-1:0] MIRROR_RST_VAL = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_OUT_RST   = 18'h00000;

    // Increment steps, two when bit 0 is masked
    localparam logic [ADDR_W-1:0] STEP_ONE = 18'h00001;
    localparam logic [ADDR_W-1:0] STEP_TWO = 18'h00002;

    // Register map, byte addresses
    localparam logic [AXI_AW-1:0] REG_CTRL        = 8'h00;
    localparam logic [AXI_AW-1:0] REG_FLAGS       = 8'h04;
    localparam logic [AXI_AW-1:0] REG_PORT_BASE   = 8'h10;
    localparam logic [AXI_AW-1:0] REG_PORT_STRIDE = 8'h10;
    localparam logic [AXI_AW-1:0] REG_COUNT_OFS   = 8'h00;
    localparam logic [AXI_AW-1:0] REG_MASK_OFS    = 8'h04;
    localparam logic [AXI_AW-1:0] REG_MIRROR_OFS  = 8'h08;

    // Control register fields
    localparam int CTRL_SOFT_CLEAR_BIT = 0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control pins of one port, all active low except port_select_high
    typedef struct packed {
        logic counter_or_mask_select_n;
        logic counter_clear_n;
        logic address_strobe_n;
        logic count_enable_n;
        logic port_select_low;
        logic port_select_high;
    } bac_pins_t;

    localparam int PINS_W = $bits(bac_pins_t);
    localparam int SYNC_W = 1 + PINS_W + ADDR_W;

    // Counter state of one port
    typedef struct packed {
        logic [ADDR_W-1:0] count;
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] mirror;
        logic              wrap_n;
    } bac_state_t;

    // Operation decoded at a port clock rise
    typedef enum logic [3:0] {
        OP_HOLD,
        OP_CNT_CLR,
        OP_CNT_LOAD,
        OP_CNT_READ,
        OP_CNT_INC,
        OP_MSK_CLR,
        OP_MSK_LOAD,
        OP_MSK_READ,
        OP_RESERVED
    } bac_op_t;

endpackage

/* File: src/bac_sync.sv */
/*
 * Two-flop synchroniser for a vector of pin inputs.
 * Assumes quasi-static bits; bits moving together may land apart.
 */
`timescale 1ns/1ps
module bac_sync
    import bac_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         aclk,    // System clock
    input  wire logic         aresetn, // Synchronous reset, active low
    input  wire logic [W-1:0] d,       // Asynchronous inputs
    output logic      [W-1:0] q        // Synchronised outputs
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

/* File: src/bac_decode.sv */
/*
 * Decodes one port's four control pins into an operation.
 * Assumes the pins have already been synchronised to aclk.
 */
`timescale 1ns/1ps
module bac_decode
    import bac_pkg::*;
(
    input  wire bac_pins_t pins, // Synchronised control pins
    output bac_op_t        op    // Selected operation
);

    wire cnt_sel = pins.counter_or_mask_select_n;
    wire clr_n   = pins.counter_clear_n;
    wire ads_n   = pins.address_strobe_n;
    wire cen_n   = pins.count_enable_n;

    // Clear wins over strobe and enable; chip selects play no part
    wire bac_op_t cnt_op = !ads_n ? (!cen_n ? OP_CNT_LOAD : OP_CNT_READ)
                                  : (!cen_n ? OP_CNT_INC : OP_HOLD);
    wire bac_op_t msk_op = !ads_n ? (!cen_n ? OP_MSK_LOAD : OP_MSK_READ)
                                  : OP_RESERVED;

    assign op = !clr_n ? (cnt_sel ? OP_CNT_CLR : OP_MSK_CLR)
                       : (cnt_sel ? cnt_op : msk_op);

endmodule

/* File: verification/bac_top_asserts.sv */
/* Concurrent checks on bac_top ports: bus answers, readback, wrap flag.
   Bound from the bench top; assumes the single aclk domain. */
`timescale 1ns/1ps
module bac_top_asserts
    import bac_pkg::*;
(
    input wire logic      aclk, // Clock
    input wire logic      aresetn, // Reset
    input wire logic      master_clear_n, // Master clear
    input wire logic      s_axi_awvalid, // AW valid
    input wire logic      s_axi_awready, // AW ready
    input wire logic      s_axi_wvalid, // W valid
    input wire logic      s_axi_wready, // W ready
    input wire logic      s_axi_bvalid, // B valid
    input wire logic      s_axi_bready, // B ready
    input wire logic      s_axi_arvalid, // AR valid
    input wire logic      s_axi_arready, // AR ready
    input wire logic      s_axi_rvalid, // R valid
    input wire logic      port_clk [NUM_PORTS], // Port clocks
    input wire bac_pins_t port_ctl [NUM_PORTS], // Port pins
    input wire logic      addr_oe_n [NUM_PORTS], // Address drive
    input wire logic      data_float [NUM_PORTS], // Data float
    input wire logic      count_wrap_flag_n [NUM_PORTS] // Wrap flags
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Port checks other than a_mclr_flags watch port 0, where most traffic goes
    a_mclr_flags: assert property (
        !master_clear_n |-> count_wrap_flag_n[0] && count_wrap_flag_n[1])
        else $error("wrap flag low during master clear");
    a_flag_at_edge: assert property (
        $changed(count_wrap_flag_n[0]) && master_clear_n && $past(master_clear_n)
        && $past(aresetn) && !$past(s_axi_bvalid) |-> $past(port_clk[0], 2))
        else $error("wrap flag moved without a port clock rise");
    a_float_oe: assert property (data_float[0] |-> !addr_oe_n[0])
        else $error("data floated outside readback");
    a_float_sel: assert property (
        $rose(data_float[0]) |-> !port_ctl[0].port_select_low && port_ctl[0].port_select_high)
        else $error("data floated with port not enabled");
    a_oe_edge: assert property ($fell(addr_oe_n[0]) |-> $past(port_clk[0], 2))
        else $error("readback drive without a port clock rise");
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
        else $error("read answer late");
    a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");

    c_wrap: cover property (!count_wrap_flag_n[0]);
    c_float: cover property ($rose(data_float[0]));
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

/* File: verification/bac_host_model.sv */
/* Host controller model for one port: port clock, control pins, address.
   Assumes the bench aclk; pins settle well around each port clock rise. */
`timescale 1ns/1ps
module bac_host_model
    import bac_pkg::*;
(
    input  wire logic         aclk, // Bench clock
    output logic              pclk, // Port clock, still between ops
    output bac_pins_t         ctl,  // Control pins
    output logic [ADDR_W-1:0] addr  // Address lines
);
    initial begin
        pclk = 1'b0;
        ctl  = '1;
        addr = '0;
    end

    // One port cycle, slow for the pin synchronisers
    task automatic op(input logic [3:0] o, input logic [1:0] ps, input logic [ADDR_W-1:0] a);
        @(posedge aclk);
        ctl  <= {o, ps};
        addr <= a;
        repeat (3) @(posedge aclk);
        pclk <= 1'b1;
        repeat (5) @(posedge aclk);
        pclk <= 1'b0;
        addr <= ~a; // Released lines show the inverse
        repeat (3) @(posedge aclk);
    endtask
endmodule

/* File: verification/tb_top.sv */
/* Bench for bac_top: host models, AXI4-Lite master, queued reference model.
   Assumes the bac_pkg constants. */
`timescale 1ns/1ps
module tb_top;
    import bac_pkg::*;
    logic              aclk = 0, aresetn = 0, master_clear_n = 1;
    logic [7:0]        awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata;
    logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp, fq;
    logic              pclk [NUM_PORTS], oe_n [NUM_PORTS], flt [NUM_PORTS], wrap_n [NUM_PORTS];
    bac_pins_t         ctl [NUM_PORTS];
    logic [ADDR_W-1:0] ain [NUM_PORTS], aout [NUM_PORTS], cq [NUM_PORTS], mq [NUM_PORTS];
    logic [ADDR_W-1:0] rq [NUM_PORTS];
    logic [33:0]       q [$];
    logic [19:0]       qa [$];
    int                n_errors = 0, compares = 0;

    always #2.5 aclk = ~aclk;

    bac_top dut_u (.aclk, .aresetn, .master_clear_n, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_clk(pclk),
        .port_ctl(ctl), .addr_in(ain), .addr_out(aout), .addr_oe_n(oe_n),
        .data_float(flt), .count_wrap_flag_n(wrap_n));
    bac_host_model host_u0 (.aclk, .pclk(pclk[0]), .ctl(ctl[0]), .addr(ain[0]));
    bac_host_model host_u1 (.aclk, .pclk(pclk[1]), .ctl(ctl[1]), .addr(ain[1]));

    task automatic end_of_test();
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        compares++;
        if (e !== g) begin
            n_errors++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // One bus transfer, answer noted first
    task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        int i;
        q.push_back(e);
        @(posedge aclk);
        if (w) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (arvalid && arready) arvalid <= 1'b0;
            if (bvalid || rvalid) break;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        if (i == 50) begin
            n_errors++;
            end_of_test();
        end
    endtask

    // Counter, mask and mirror of one port, and both wrap flags, against the model
    task automatic check(input int p);
        logic [7:0] b;
        b = REG_PORT_BASE + 8'(p) * REG_PORT_STRIDE;
        axi(0, b, 32'h0, {RESP_OKAY, 14'h0, cq[p]});
        axi(0, b + REG_MASK_OFS, 32'h0, {RESP_OKAY, 14'h0, mq[p]});
        axi(0, b + REG_MIRROR_OFS, 32'h0, {RESP_OKAY, 14'h0, rq[p]});
        axi(0, REG_FLAGS, 32'h0, {RESP_OKAY, 30'h0, fq});
    endtask

    task automatic wipe();
        foreach (cq[p]) begin
            cq[p] = '0;
            mq[p] = '1;
            rq[p] = '0;
        end
        fq = 2'b11;
    endtask

    // Port op {select, clear, strobe, enable}, model, readback
    task automatic doop(input int p, input logic [3:0] o, input logic [1:0] ps,
                        input logic [17:0] a);
        logic [17:0] c, m;
        c = cq[p];
        m = mq[p];
        if (p == 0) qa.push_back(o[2:0] == 3'b101 ? {1'b0, ps == 2'b01, o[3] ? c : m} : 20'h80000);
        if (p == 0) host_u0.op(o, ps, a);
        else host_u1.op(o, ps, a);
        casez (o)
            4'b10??: begin
                c = c & ~m;
                rq[p] = c;
                fq[p] = 1'b1;
            end
            4'b1100: begin
                c = a;
                rq[p] = a;
                fq[p] = 1'b1;
            end
            4'b1110: begin
                c = ((c & m) == m) ? rq[p] : (c & ~m) | ((c + (m[0] ? 18'h1 : 18'h2)) & m);
                fq[p] = (c & m) != m;
            end
            4'b00??: begin
                m = '1;
                fq[p] = 1'b1;
            end
            4'b0100: begin
                m = a;
                fq[p] = 1'b1;
            end
            default: ; // Hold, readback and reserved keep everything
        endcase
        cq[p] = c;
        mq[p] = m;
        check(p);
    endtask

    // Watchers: bus answers, port 0 readback
    always @(posedge aclk) begin
        if (rvalid && rready) cmp(q.pop_front(), {rresp, rdata});
        if (bvalid && bready) cmp(q.pop_front(), {bresp, 32'h0});
    end
    always @(posedge pclk[0]) begin
        repeat (6) @(posedge aclk);
        cmp(34'(qa.pop_front()), 34'({oe_n[0], flt[0], oe_n[0] ? 18'h0 : aout[0]}));
    end

    initial begin
        int n;
        logic [3:0] o;
        logic [17:0] a;
        void'($urandom(80));
        wipe();
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        check(0);
        check(1);
        axi(0, 8'h0c, 32'h0, {RESP_SLVERR, 32'h0});
        axi(1, 8'h10, 32'h5, {RESP_SLVERR, 32'h0});
        doop(0, 4'b0100, 2'b01, 18'h3);
        doop(0, 4'b1100, 2'b01, 18'h8);
        repeat (7) doop(0, 4'b1110, 2'b01, 18'h0);
        doop(0, {1'b1, wrap_n[0], 2'b10}, 2'b01, 18'h0);
        doop(0, 4'b1101, 2'b01, 18'h0);
        doop(0, 4'b0101, 2'b10, 18'h0);
        doop(0, 4'b0011, 2'b00, 18'h0);
        doop(0, 4'b1011, 2'b00, 18'h0);
        for (int i = 0; i < 150; i++) begin
            o = $urandom % 2 ? 4'b1110 : 4'($urandom);
            n = $urandom_range(18, 1);
            a = o == 4'b0100 ? 18'((1 << n) - 1 - (n > 1 ? $urandom % 2 : 0)) : 18'($urandom);
            doop(int'($urandom % 4 == 0), o, 2'($urandom), a);
        end
        @(posedge aclk);
        master_clear_n <= 1'b0;
        repeat (2) @(posedge aclk);
        master_clear_n <= 1'b1;
        wipe();
        check(0);
        check(1);
        doop(0, 4'b1100, 2'b11, 18'h155);
        axi(1, REG_CTRL, 32'h1, {RESP_OKAY, 32'h0});
        wipe();
        check(0);
        end_of_test();
    end
endmodule

bind bac_top bac_top_asserts chk_u (.aclk, .aresetn, .master_clear_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .port_clk, .port_ctl, .addr_oe_n, .data_float,
    .count_wrap_flag_n);
